// ---- rtl/pmx_pkg.sv ----
// Package for the port A upper pin multiplexer: map, fields, encodings
package pmx_pkg;

	localparam int          PMX_PINS       = 4;
	localparam int          PMX_TIMERS     = 5;
	localparam int          PMX_FSEL_W     = 2 * PMX_PINS;

	// Register byte offsets
	localparam logic [7:0]  OFF_GPIO_DATA  = 8'h00;
	localparam logic [7:0]  OFF_GPIO_DIR   = 8'h04;
	localparam logic [7:0]  OFF_GPIO_PULL  = 8'h08;
	localparam logic [7:0]  OFF_PIN_STATE  = 8'h0C;
	localparam logic [7:0]  OFF_FUNC_SEL   = 8'h10;
	localparam logic [7:0]  OFF_ALT_ROUTE  = 8'h14;
	localparam logic [7:0]  OFF_MODE_STATE = 8'h18;

	// Reset values
	localparam logic [3:0]  RST_GPIO_DATA  = 4'h0;
	localparam logic [3:0]  RST_GPIO_DIR   = 4'h0;
	localparam logic [3:0]  RST_GPIO_PULL  = 4'hF;
	localparam logic [3:0]  RST_PAD_PULL   = 4'hF;
	localparam logic [7:0]  RST_FUNC_SEL   = 8'h00;
	localparam logic [1:0]  RST_ALT_ROUTE  = 2'h0;

	// Pin indices within the block
	localparam int          PIN_TEN        = 0;
	localparam int          PIN_ELEVEN     = 1;
	localparam int          PIN_TWELVE     = 2;
	localparam int          PIN_THIRTEEN   = 3;

	// Timer channel indices
	localparam int          TMR_B_ONE      = 0;
	localparam int          TMR_B_TWO      = 1;
	localparam int          TMR_B_THREE    = 2;
	localparam int          TMR_A_ONE      = 3;
	localparam int          TMR_A_TWO      = 4;

	// Alternate route bits
	localparam int          ALT_PB_ELEVEN  = 0;
	localparam int          ALT_PB_FIVE    = 1;

	// AHB transfer type bit that marks an active transfer
	localparam int          HTRANS_ACTIVE  = 1;

	// Function select code per pin (two bits, pin n at bits 2n+1:2n)
	typedef enum logic [1:0] {
		FN_GPIO,
		FN_ALT1,
		FN_ALT2,
		FN_ALT3
	} pmx_func_t;

	// Timer channel drives and pad drives
	typedef struct packed {
		logic [PMX_TIMERS-1:0] out;
		logic [PMX_TIMERS-1:0] oe;
	} pmx_timer_t;

	typedef struct packed {
		logic out;
		logic oe;
	} pmx_drive_t;

endpackage

// ---- rtl/pmx_pin_mux.sv ----
// Pin multiplexer for port A pins ten to thirteen with AHB-Lite registers
//
// Contract
// - Each pin in GPIO mode has its own software direction bit.
// - Pin ten resets to GPIO; options timer_b_chan_two or comparator_a_input_two.
// - Pin eleven resets to GPIO; options timer_b_chan_three or comparator_b_input_two.
// - Pin twelve resets to GPIO; options serial clock, timer_b_chan_one, timer_a_chan_one.
// - Pin thirteen resets to GPIO; options serial slave-out, timer_b_chan_two, timer_a_chan_two.
// - Peripheral selection per pin comes from function select register settings.
// - timer_b_chan_two may appear on pin thirteen as well as pin ten.
// - timer_b_chan_one may also be routed to port B pin eleven.
// - timer_a_chan_one may also be routed to port B pin five.
// - Serial master drives the clock pin as an output.
// - Serial slave takes the clock pin as its input clock.
// - Slave-out pin is input for master, output for slave.
// - Unselected slave leaves slave-out pin undriven.
// - Slave data leads the sampling clock edge by half a period.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module pmx_pin_mux
	import pmx_pkg::*;
(
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// Port A pads ten to thirteen
	input  wire logic [PMX_PINS-1:0]   pad_in,
	output logic      [PMX_PINS-1:0]   pad_out,
	output logic      [PMX_PINS-1:0]   pad_oe,
	output logic      [PMX_PINS-1:0]   pad_pull,
	output logic      [PMX_PINS-1:0]   pad_analog,
	// Port B alternate pads
	input  wire logic                  port_b_pin_eleven_in,
	input  wire logic                  port_b_pin_five_in,
	output pmx_drive_t                 port_b_pin_eleven_drive,
	output pmx_drive_t                 port_b_pin_five_drive,
	// Timers
	input  pmx_timer_t                 timer_drive,
	output logic      [PMX_TIMERS-1:0] timer_in,
	// Serial interface one
	input  wire logic                  serial_if_one_master,
	input  wire logic                  serial_if_one_select_n,
	input  wire logic                  serial_if_one_clock_out,
	input  wire logic                  serial_if_one_slave_out,
	output logic                       serial_if_one_clock_in,
	output logic                       serial_if_one_slave_in
);

	////////////////////////////////////////////////////////////////////////
	// Registers and pin synchronisers

	logic [PMX_PINS-1:0]   gpio_data;
	logic [PMX_PINS-1:0]   gpio_dir;
	logic [PMX_PINS-1:0]   gpio_pull;
	logic [PMX_FSEL_W-1:0] func_sel;
	logic [1:0]            alt_route;
	logic [PMX_PINS-1:0]   pin_meta;
	logic [PMX_PINS-1:0]   pin_sync;
	logic [1:0]            pb_meta;
	logic [1:0]            pb_sync;
	logic                  wr_pend;
	logic [7:0]            wr_addr;
	logic                  addr_ok;
	logic [7:0]            a_off;
	logic [31:0]           next_hrdata;
	pmx_func_t             fn_ten;
	pmx_func_t             fn_eleven;
	pmx_func_t             fn_twelve;
	pmx_func_t             fn_thirteen;

	assign fn_ten      = pmx_func_t'(func_sel[2*PIN_TEN +: 2]);
	assign fn_eleven   = pmx_func_t'(func_sel[2*PIN_ELEVEN +: 2]);
	assign fn_twelve   = pmx_func_t'(func_sel[2*PIN_TWELVE +: 2]);
	assign fn_thirteen = pmx_func_t'(func_sel[2*PIN_THIRTEEN +: 2]);

	always_ff @(posedge clock) begin
		if (rst) begin
			pin_meta <= '0;
			pin_sync <= '0;
			pb_meta  <= '0;
			pb_sync  <= '0;
		end else begin
			pin_meta <= pad_in;
			pin_sync <= pin_meta;
			pb_meta  <= {port_b_pin_five_in, port_b_pin_eleven_in};
			pb_sync  <= pb_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY

	assign addr_ok = hsel && htrans[HTRANS_ACTIVE] && hready;
	assign a_off   = haddr[7:0];

	always_comb begin
		next_hrdata = '0;
		if (haddr[31:8] == 24'h000000) begin
			unique case (a_off)
				OFF_GPIO_DATA:  next_hrdata = {28'h0000000, gpio_data};
				OFF_GPIO_DIR:   next_hrdata = {28'h0000000, gpio_dir};
				OFF_GPIO_PULL:  next_hrdata = {28'h0000000, gpio_pull};
				OFF_PIN_STATE:  next_hrdata = {28'h0000000, pin_sync};
				OFF_FUNC_SEL:   next_hrdata = {24'h000000, func_sel};
				OFF_ALT_ROUTE:  next_hrdata = {30'h00000000, alt_route};
				OFF_MODE_STATE: next_hrdata = {30'h00000000, serial_if_one_select_n, serial_if_one_master};
				default:        next_hrdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_ok && !hwrite) begin
				hrdata <= next_hrdata;
			end
		end
	end

	// Write address phase held until data phase
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end else begin
			wr_pend <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
			wr_addr <= a_off;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			gpio_data <= RST_GPIO_DATA;
			gpio_dir  <= RST_GPIO_DIR;
			gpio_pull <= RST_GPIO_PULL;
			func_sel  <= RST_FUNC_SEL;
			alt_route <= RST_ALT_ROUTE;
		end else if (wr_pend) begin
			unique case (wr_addr)
				OFF_GPIO_DATA: gpio_data <= hwdata[PMX_PINS-1:0];
				OFF_GPIO_DIR:  gpio_dir  <= hwdata[PMX_PINS-1:0];
				OFF_GPIO_PULL: gpio_pull <= hwdata[PMX_PINS-1:0];
				OFF_FUNC_SEL:  func_sel  <= hwdata[PMX_FSEL_W-1:0];
				OFF_ALT_ROUTE: alt_route <= hwdata[1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pad steering

	logic [PMX_PINS-1:0] next_pad_out;
	logic [PMX_PINS-1:0] next_pad_oe;
	logic [PMX_PINS-1:0] next_pad_pull;
	logic [PMX_PINS-1:0] next_pad_analog;

	always_comb begin
		// GPIO default, pull-up only while an input
		next_pad_out    = gpio_data;
		next_pad_oe     = gpio_dir;
		next_pad_pull   = gpio_pull & ~gpio_dir;
		next_pad_analog = '0;

		unique case (fn_ten)
			FN_ALT1: begin
				next_pad_out[PIN_TEN]  = timer_drive.out[TMR_B_TWO];
				next_pad_oe[PIN_TEN]   = timer_drive.oe[TMR_B_TWO];
			end
			FN_ALT2: begin
				next_pad_oe[PIN_TEN]     = 1'b0;
				next_pad_pull[PIN_TEN]   = 1'b0;
				next_pad_analog[PIN_TEN] = 1'b1;
			end
			default: ;
		endcase

		unique case (fn_eleven)
			FN_ALT1: begin
				next_pad_out[PIN_ELEVEN] = timer_drive.out[TMR_B_THREE];
				next_pad_oe[PIN_ELEVEN]  = timer_drive.oe[TMR_B_THREE];
			end
			FN_ALT2: begin
				next_pad_oe[PIN_ELEVEN]     = 1'b0;
				next_pad_pull[PIN_ELEVEN]   = 1'b0;
				next_pad_analog[PIN_ELEVEN] = 1'b1;
			end
			default: ;
		endcase

		unique case (fn_twelve)
			FN_ALT1: begin
				// Master drives clock out, slave receives it
				next_pad_out[PIN_TWELVE] = serial_if_one_clock_out;
				next_pad_oe[PIN_TWELVE]  = serial_if_one_master;
			end
			FN_ALT2: begin
				next_pad_out[PIN_TWELVE] = timer_drive.out[TMR_B_ONE];
				next_pad_oe[PIN_TWELVE]  = timer_drive.oe[TMR_B_ONE];
			end
			FN_ALT3: begin
				next_pad_out[PIN_TWELVE] = timer_drive.out[TMR_A_ONE];
				next_pad_oe[PIN_TWELVE]  = timer_drive.oe[TMR_A_ONE];
			end
			default: ;
		endcase

		unique case (fn_thirteen)
			FN_ALT1: begin
				// Slave drives only while selected
				next_pad_out[PIN_THIRTEEN] = serial_if_one_slave_out;
				next_pad_oe[PIN_THIRTEEN]  = !serial_if_one_master && !serial_if_one_select_n;
			end
			FN_ALT2: begin
				next_pad_out[PIN_THIRTEEN] = timer_drive.out[TMR_B_TWO];
				next_pad_oe[PIN_THIRTEEN]  = timer_drive.oe[TMR_B_TWO];
			end
			FN_ALT3: begin
				next_pad_out[PIN_THIRTEEN] = timer_drive.out[TMR_A_TWO];
				next_pad_oe[PIN_THIRTEEN]  = timer_drive.oe[TMR_A_TWO];
			end
			default: ;
		endcase
	end

	// Clock and data pads share one flop stage so their phase holds
	always_ff @(posedge clock) begin
		if (rst) begin
			pad_out    <= '0;
			pad_oe     <= '0;
			pad_pull   <= RST_PAD_PULL;
			pad_analog <= '0;
		end else begin
			pad_out    <= next_pad_out;
			pad_oe     <= next_pad_oe;
			pad_pull   <= next_pad_pull;
			pad_analog <= next_pad_analog;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Inputs toward peripherals and port B routes

	always_ff @(posedge clock) begin
		if (rst) begin
			timer_in               <= '0;
			serial_if_one_clock_in <= 1'b0;
			serial_if_one_slave_in <= 1'b0;
		end else begin
			timer_in[TMR_B_ONE]    <= alt_route[ALT_PB_ELEVEN] ? pb_sync[ALT_PB_ELEVEN] : pin_sync[PIN_TWELVE];
			timer_in[TMR_B_TWO]    <= (fn_thirteen == FN_ALT2) ? pin_sync[PIN_THIRTEEN] : pin_sync[PIN_TEN];
			timer_in[TMR_B_THREE]  <= pin_sync[PIN_ELEVEN];
			timer_in[TMR_A_ONE]    <= alt_route[ALT_PB_FIVE] ? pb_sync[ALT_PB_FIVE] : pin_sync[PIN_TWELVE];
			timer_in[TMR_A_TWO]    <= pin_sync[PIN_THIRTEEN];
			serial_if_one_clock_in <= pin_sync[PIN_TWELVE];
			serial_if_one_slave_in <= pin_sync[PIN_THIRTEEN];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			port_b_pin_eleven_drive <= '0;
			port_b_pin_five_drive   <= '0;
		end else begin
			port_b_pin_eleven_drive.out <= timer_drive.out[TMR_B_ONE];
			port_b_pin_eleven_drive.oe  <= timer_drive.oe[TMR_B_ONE] && alt_route[ALT_PB_ELEVEN];
			port_b_pin_five_drive.out   <= timer_drive.out[TMR_A_ONE];
			port_b_pin_five_drive.oe    <= timer_drive.oe[TMR_A_ONE] && alt_route[ALT_PB_FIVE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_fsel_addr;
		addr_ok && hwrite && (haddr == {24'h000000, OFF_FUNC_SEL});
	endsequence

	sequence s_fsel_write;
		s_fsel_addr ##1 1'b1;
	endsequence

	AST_RESET_INPUT: assert property (@(posedge clock) disable iff (rst)
		$past(rst) |-> (pad_oe == '0) && (pad_pull == RST_PAD_PULL))
		else $error("pads not input with pull-up after reset");

	AST_DEFAULT_GPIO: assert property (@(posedge clock) disable iff (rst)
		$past(rst) |-> (func_sel == RST_FUNC_SEL) && (pad_analog == '0))
		else $error("pins not in GPIO mode after reset");

	AST_FSEL_WRITE: assert property (@(posedge clock) disable iff (rst)
		s_fsel_write |=> (func_sel == $past(hwdata[PMX_FSEL_W-1:0])))
		else $error("function select write not applied");

	AST_GPIO_DIR: assert property (@(posedge clock) disable iff (rst)
		(fn_eleven == FN_GPIO) |=> (pad_oe[PIN_ELEVEN] == $past(gpio_dir[PIN_ELEVEN])))
		else $error("GPIO direction not followed");

	AST_CMP_NO_DRIVE: assert property (@(posedge clock) disable iff (rst)
		(fn_ten == FN_ALT2) |=> !pad_oe[PIN_TEN] && pad_analog[PIN_TEN] && !pad_pull[PIN_TEN])
		else $error("comparator pin still driven");

	AST_SCLK_MASTER: assert property (@(posedge clock) disable iff (rst)
		(fn_twelve == FN_ALT1) && serial_if_one_master
		|=> pad_oe[PIN_TWELVE] && (pad_out[PIN_TWELVE] == $past(serial_if_one_clock_out)))
		else $error("master clock not driven");

	AST_SCLK_SLAVE: assert property (@(posedge clock) disable iff (rst)
		(fn_twelve == FN_ALT1) && !serial_if_one_master |=> !pad_oe[PIN_TWELVE])
		else $error("slave clock pin driven");

	AST_CLK_IN_PATH: assert property (@(posedge clock) disable iff (rst)
		1'b1 ##3 1'b1 |-> (serial_if_one_clock_in == $past(pad_in[PIN_TWELVE], 3)))
		else $error("clock input path latency wrong");

	AST_MISO_HIZ: assert property (@(posedge clock) disable iff (rst)
		(fn_thirteen == FN_ALT1) && (serial_if_one_select_n || serial_if_one_master) |=> !pad_oe[PIN_THIRTEEN])
		else $error("slave-out driven while unselected or master");

	AST_MISO_SLAVE: assert property (@(posedge clock) disable iff (rst)
		(fn_thirteen == FN_ALT1) && !serial_if_one_master && !serial_if_one_select_n
		|=> pad_oe[PIN_THIRTEEN] && (pad_out[PIN_THIRTEEN] == $past(serial_if_one_slave_out)))
		else $error("selected slave not driving data");

	AST_TB2_PIN13: assert property (@(posedge clock) disable iff (rst)
		(fn_thirteen == FN_ALT2) |=> (pad_oe[PIN_THIRTEEN] == $past(timer_drive.oe[TMR_B_TWO])))
		else $error("timer B two not on pin thirteen");

	AST_PB11_ROUTE: assert property (@(posedge clock) disable iff (rst)
		!alt_route[ALT_PB_ELEVEN] |=> !port_b_pin_eleven_drive.oe)
		else $error("port B eleven driven without route");

	AST_PB5_ROUTE: assert property (@(posedge clock) disable iff (rst)
		alt_route[ALT_PB_FIVE] && timer_drive.oe[TMR_A_ONE] |=> port_b_pin_five_drive.oe)
		else $error("port B five not driven when routed");

endmodule

// ---- verif/pmx_partner.sv ----
// Model of the on-chip timers and the serial interface beside the pin multiplexer
`timescale 1ns/10ps
module pmx_partner
	import pmx_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Mode requested by the bench
	input  wire logic want_master,
	input  wire logic want_sel_n,
	// Timer drives and pin side of the serial interface
	input  wire logic clock_in,
	output pmx_timer_t timer_drive,
	output logic       master,
	output logic       select_n,
	output logic       clock_out,
	output logic       slave_out
);
	logic tick;
	logic clk_in_q;

	////////////////////////////////////////////////////////////////
	// Timers change every cycle, as free-running channels do
	always_ff @(posedge clock) begin
		timer_drive <= rst ? '0 : 10'($urandom);
	end

	always_ff @(posedge clock) begin
		master   <= rst ? 1'b0 : want_master;
		select_n <= rst ? 1'b1 : want_sel_n;
	end

	// Clock runs only in master mode, still otherwise
	always_ff @(posedge clock) begin
		if (rst || !master) begin
			tick      <= 1'b0;
			clock_out <= 1'b0;
		end else begin
			tick <= ~tick;
			if (tick)
				clock_out <= ~clock_out;
		end
	end

	// Selected slave: new bit on the falling clock edge, half a period ahead of sampling; toggles every cycle otherwise
	always_ff @(posedge clock) begin
		clk_in_q <= clock_in;
		if (rst)
			slave_out <= 1'b0;
		else if (select_n || master)
			slave_out <= ~slave_out;
		else if (clk_in_q && !clock_in)
			slave_out <= 1'($urandom);
	end
endmodule

// ---- verif/pmx_pin_mux_tb_top.sv ----
// Self-checking testbench for the port A upper pin multiplexer
`timescale 1ns/10ps
module pmx_pin_mux_tb_top
	import pmx_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst   = 1'b1;
	logic        hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [3:0]  pad_in, pad_out, pad_oe, pad_pull, pad_analog, dir, data, pull;
	logic        pb11_in, pb5_in, master, select_n, sclk_out, sout, sclk_in, sin, want_m, want_sn;
	pmx_drive_t  pb11_drv, pb5_drv;
	pmx_timer_t  timer_drive, td;
	logic [4:0]  timer_in;
	logic [7:0]  fsel;
	logic [1:0]  alt;
	logic        co, so, m, sn;
	int          miscompares = 0;
	int          num_checks  = 0;
	int          cycles      = 0;

	always #2.5 clock = ~clock;

	pmx_pin_mux pmx_pin_mux_inst (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull(pad_pull), .pad_analog(pad_analog), .port_b_pin_eleven_in(pb11_in),
		.port_b_pin_five_in(pb5_in), .port_b_pin_eleven_drive(pb11_drv), .port_b_pin_five_drive(pb5_drv),
		.timer_drive(timer_drive), .timer_in(timer_in), .serial_if_one_master(master),
		.serial_if_one_select_n(select_n), .serial_if_one_clock_out(sclk_out),
		.serial_if_one_slave_out(sout), .serial_if_one_clock_in(sclk_in), .serial_if_one_slave_in(sin));

	pmx_partner pmx_partner_inst (.clock(clock), .rst(rst), .want_master(want_m), .want_sel_n(want_sn),
		.clock_in(sclk_in), .timer_drive(timer_drive), .master(master), .select_n(select_n),
		.clock_out(sclk_out), .slave_out(sout));

	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			conclude();
		end
	end

	// Single AHB-Lite transfer, entered just after a rising edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
		check(32'(hresp), 32'h0, "hresp");
	endtask

	////////////////////////////////////////////////////////////////
	// Expected pad drive as {out masked by enable, enable}
	function automatic logic [1:0] exp_pad(input int p);
		logic [1:0] r;
		case (p * 4 + int'(fsel[2*p+:2]))
			1:       r = {td.out[TMR_B_TWO], td.oe[TMR_B_TWO]};
			5:       r = {td.out[TMR_B_THREE], td.oe[TMR_B_THREE]};
			2, 6:    r = 2'h0;
			9:       r = {co, m};
			10:      r = {td.out[TMR_B_ONE], td.oe[TMR_B_ONE]};
			11:      r = {td.out[TMR_A_ONE], td.oe[TMR_A_ONE]};
			13:      r = {so, !m && !sn};
			14:      r = {td.out[TMR_B_TWO], td.oe[TMR_B_TWO]};
			15:      r = {td.out[TMR_A_TWO], td.oe[TMR_A_TWO]};
			default: r = {data[p], dir[p]};
		endcase
		return {r[1] & r[0], r[0]};
	endfunction

	function automatic logic [4:0] exp_tin();
		logic [4:0] r;
		r[TMR_B_ONE]   = alt[ALT_PB_ELEVEN] ? pb11_in : pad_in[PIN_TWELVE];
		r[TMR_B_TWO]   = (fsel[7:6] == 2'h2) ? pad_in[PIN_THIRTEEN] : pad_in[PIN_TEN];
		r[TMR_B_THREE] = pad_in[PIN_ELEVEN];
		r[TMR_A_ONE]   = alt[ALT_PB_FIVE] ? pb5_in : pad_in[PIN_TWELVE];
		r[TMR_A_TWO]   = pad_in[PIN_THIRTEEN];
		return r;
	endfunction

	// Sample what the mux sees at each edge, compare just after it
	task automatic chk_cycles(input int n);
		logic [1:0] c;
		logic [1:0] e;
		repeat (n) begin
			@(posedge clock);
			td = timer_drive;
			co = sclk_out;
			so = sout;
			m  = master;
			sn = select_n;
			#1;
			for (int p = 0; p < 4; p++) begin
				c = fsel[2*p+:2];
				check(32'({pad_out[p] & pad_oe[p], pad_oe[p]}), 32'(exp_pad(p)), "pad");
				check(32'(pad_analog[p]), 32'(p < 2 && c == 2'h2), "analog");
				if (p < 2 && c == 2'h2)
					check(32'(pad_pull[p]), 32'h0, "analog pull");
				else if (c == 2'h0 || (p < 2 && c == 2'h3))
					check(32'(pad_pull[p]), 32'(pull[p] & ~dir[p]), "pull");
			end
			// Unrouted port B pads must stay undriven
			e = alt[ALT_PB_ELEVEN] ? exp_pad_t(TMR_B_ONE) : 2'h0;
			check(32'({pb11_drv.out & pb11_drv.oe, pb11_drv.oe}), 32'(e), "pb11");
			e = alt[ALT_PB_FIVE] ? exp_pad_t(TMR_A_ONE) : 2'h0;
			check(32'({pb5_drv.out & pb5_drv.oe, pb5_drv.oe}), 32'(e), "pb5");
		end
	endtask

	function automatic logic [1:0] exp_pad_t(input int t);
		return {td.out[t] & td.oe[t], td.oe[t]};
	endfunction

	task automatic program_regs();
		ahb(1'b1, OFF_GPIO_DATA, 32'(data), rd);
		ahb(1'b1, OFF_GPIO_DIR, 32'(dir), rd);
		ahb(1'b1, OFF_GPIO_PULL, 32'(pull), rd);
		ahb(1'b1, OFF_FUNC_SEL, 32'(fsel), rd);
		ahb(1'b1, OFF_ALT_ROUTE, 32'(alt), rd);
		repeat (3) @(posedge clock);
	endtask

	task automatic reset_checks();
		@(posedge clock);
		#1;
		check(32'(pad_oe), 32'h0, "reset oe");
		check(32'(pad_pull), 32'(RST_PAD_PULL), "reset pull");
		check(32'(pad_analog), 32'h0, "reset analog");
		@(posedge clock);
		rst <= 1'b0;
		{fsel, dir, data, pull, alt} = {RST_FUNC_SEL, RST_GPIO_DIR, RST_GPIO_DATA, RST_GPIO_PULL, RST_ALT_ROUTE};
		ahb(1'b0, OFF_FUNC_SEL, 32'h0, rd);
		check(rd, 32'(RST_FUNC_SEL), "reset fsel");
		ahb(1'b0, OFF_GPIO_DIR, 32'h0, rd);
		check(rd, 32'(RST_GPIO_DIR), "reset dir");
		ahb(1'b0, OFF_GPIO_PULL, 32'h0, rd);
		check(rd, 32'(RST_GPIO_PULL), "reset pull reg");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{pad_in, pb11_in, pb5_in, want_m, want_sn} = 8'h01;
		void'($urandom(82));
		reset_checks();
		ahb(1'b1, 8'h1C, 32'hFFFFFFFF, rd);
		ahb(1'b0, 8'h1C, 32'h0, rd);
		check(rd, 32'h0, "unmapped");
		for (int i = 0; i < 24; i++) begin
			fsel    = (i < 8) ? {4{i[1:0]}} : 8'($urandom);
			want_m <= (i < 8) ? i[2] : 1'($urandom);
			want_sn <= 1'($urandom);
			{dir, data, pull, alt} = 14'($urandom);
			pad_in  <= 4'($urandom);
			pb11_in <= 1'($urandom);
			pb5_in  <= 1'($urandom);
			program_regs();
			chk_cycles(6);
			check(32'(timer_in), 32'(exp_tin()), "timer in");
			if (master)
				check(32'(sin), 32'(pad_in[PIN_THIRTEEN]), "slave in");
			else
				check(32'(sclk_in), 32'(pad_in[PIN_TWELVE]), "clock in");
			@(posedge clock);
			ahb(1'b0, OFF_PIN_STATE, 32'h0, rd);
			check(rd, 32'(pad_in), "pin state");
			ahb(1'b0, OFF_MODE_STATE, 32'h0, rd);
			check(rd, {30'h0, select_n, master}, "mode");
		end
		// Selected slave with the pin clock toggling
		fsel = 8'h50;
		want_m  <= 1'b0;
		want_sn <= 1'b0;
		program_regs();
		fork
			repeat (12) begin
				@(posedge clock);
				pad_in[PIN_TWELVE] <= ~pad_in[PIN_TWELVE];
				@(posedge clock);
			end
			chk_cycles(24);
		join
		@(posedge clock);
		rst <= 1'b1;
		reset_checks();
		conclude();
	end
endmodule
